/* rtl/ahts_params.svh */
// offsets, field positions and reset values of the host transfer status bank
`ifndef AHTS_PARAMS_SVH
`define AHTS_PARAMS_SVH
`define AHTS_OFF_START_MATCH 8'hcd
`define AHTS_OFF_TASK_MIRROR 8'hce
`define AHTS_OFF_FIFO_LEVEL 8'hcf
`define AHTS_OFF_XFER_LOW 8'hd0
`define AHTS_OFF_XFER_HIGH 8'hd1
`define AHTS_OFF_CHECK_SIZE 8'hd2
`define AHTS_OFF_CHECK_PROG 8'hd3
`define AHTS_OFF_CARD_OPTION 8'he0
`define AHTS_BIT_DMA_SEEN 6
`define AHTS_BIT_HEAD_LIMIT 5
`define AHTS_BIT_SECTOR_LIMIT 4
`define AHTS_BIT_DRVHD_MATCH 2
`define AHTS_BIT_CYL_MATCH 1
`define AHTS_BIT_SEC_MATCH 0
`define AHTS_BIT_NINTH 3
`define AHTS_BIT_TF_DRQ 3
`define AHTS_BIT_TF_BUSY 7
`define AHTS_BIT_DRIVE_SEL 4
`define AHTS_FIFO_FULL 6'h20
`define AHTS_FIFO_RESET 6'h00
`define AHTS_RESET_BYTE 8'h00
`endif

/* rtl/ahts_pkg.sv */
// types shared by the host transfer status bank
package ahts_pkg;
    typedef enum logic [3:0] {
        AHTS_MODE_MEMORY, AHTS_MODE_BLOCK_IO, AHTS_MODE_PRIMARY_IO, AHTS_MODE_SECONDARY_IO,
        AHTS_MODE_PRIMARY_FLOPPY, AHTS_MODE_SECONDARY_FLOPPY, AHTS_MODE_RESERVED
    } ahts_mode_e;
    typedef struct packed {
        logic [7:0] sector_number;
        logic [7:0] cylinder_low;
        logic [7:0] cylinder_high;
        logic [7:0] drive_head;
    } ahts_addr_s;
    typedef struct packed {
        logic card_soft_reset;
        logic level_irq_select;
        logic option_spare_bit;
        logic [3:0] access_mode_index;
    } ahts_option_s;
endpackage

/* rtl/ahts_mode_decode.sv */
// decode of the card access-mode index
`timescale 1ns/100ps
module ahts_mode_decode (
    // index in
    input wire logic [3:0] access_mode_index,
    // decoded mode
    output ahts_pkg::ahts_mode_e access_mode
);
    // indexes 0..5 map one to one, the rest reserved
    assign access_mode = (access_mode_index <= 4'h5) ?
        ahts_pkg::ahts_mode_e'(access_mode_index) : ahts_pkg::AHTS_MODE_RESERVED;
endmodule

/* rtl/ahts_status_bank.sv */
// host transfer status register bank for local firmware
`timescale 1ns/100ps
`include "ahts_params.svh"
module ahts_status_bank (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // firmware register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // task file and start registers
    input wire ahts_pkg::ahts_addr_s start_regs,
    input wire ahts_pkg::ahts_addr_s taskfile_regs,
    input wire logic [3:0] head_limit_field,
    input wire logic [7:0] sector_limit_drive0,
    input wire logic [7:0] sector_limit_drive1,
    input wire logic [7:0] taskfile_status,
    input wire logic lba_command_active,
    // command decode
    input wire logic command_load,
    input wire logic command_is_dma,
    input wire logic command_for_this_drive,
    input wire logic long_command,
    // counters elsewhere
    input wire logic [7:0] host_timer_value,
    input wire logic [7:0] block_counter_value,
    input wire logic sector_count_load,
    input wire logic [7:0] sector_count_load_value,
    input wire logic sector_count_decrement,
    input wire logic [7:0] taskfile_sector_count,
    input wire logic request_gen_enable_view,
    // host fifo
    input wire logic fifo_reset_bit,
    input wire logic fifo_push,
    input wire logic fifo_pop,
    // transfer events
    input wire logic xfer_start,
    input wire logic [9:0] sector_size,
    input wire logic host_byte,
    input wire logic buffer_byte,
    input wire logic buffer_sector_done,
    // card option register image
    input wire ahts_pkg::ahts_option_s card_option,
    // derived outputs
    output logic transfer_done_irq_status,
    output ahts_pkg::ahts_mode_e access_mode
);
    logic dma_command_seen;
    logic sector_count_ninth_bit;
    logic sector_count_zero;
    logic [5:0] fifo_byte_level;
    logic [9:0] host_bytes_remaining;
    logic host_check_phase;
    logic host_side_done, buffer_side_done;
    logic host_check_done, buffer_check_done;
    logic sector_complete_status;
    logic [5:0] check_size;
    logic [5:0] check_progress;
    logic buffer_check_phase;
    logic [7:0] next_rdata;

    // continuous comparisons
    wire drive_select_bit = taskfile_regs.drive_head[`AHTS_BIT_DRIVE_SEL];
    wire [7:0] sector_limit = drive_select_bit ? sector_limit_drive1 : sector_limit_drive0;
    wire head_at_limit = start_regs.drive_head[3:0] == head_limit_field;
    wire sector_at_limit = start_regs.sector_number == sector_limit;
    wire start_drivehead_match = start_regs.drive_head == taskfile_regs.drive_head;
    wire start_cylinder_match = (start_regs.cylinder_low == taskfile_regs.cylinder_low) &&
        (start_regs.cylinder_high == taskfile_regs.cylinder_high);
    wire start_sector_match = start_regs.sector_number == taskfile_regs.sector_number;
    wire host_data_request_mirror = taskfile_status[`AHTS_BIT_TF_DRQ];
    wire host_busy_mirror = taskfile_status[`AHTS_BIT_TF_BUSY];
    wire host_timer_zero = host_timer_value == 8'h00;
    wire block_counter_zero = block_counter_value == 8'h00;
    wire any_check_phase = host_check_phase | buffer_check_phase;
    wire new_command = command_load & command_for_this_drive;

    // register write decode
    wire wr_mirror = reg_write && reg_addr == `AHTS_OFF_TASK_MIRROR;
    wire wr_check_size = reg_write && reg_addr == `AHTS_OFF_CHECK_SIZE;
    wire ninth_clear_ok = wr_mirror && !reg_wdata[`AHTS_BIT_NINTH] && host_busy_mirror;

    // transfer counter events
    wire host_count_last = host_byte && host_bytes_remaining == 10'h001;
    wire data_boundary = host_count_last && !host_check_phase;
    wire check_boundary = host_count_last && host_check_phase;
    wire enter_check = data_boundary && long_command && check_size != 6'h00;
    wire buffer_check_last = buffer_byte && buffer_check_phase &&
        check_progress == check_size - 6'h01;

    // fifo level with next value
    logic [5:0] next_fifo_level;
    always_comb begin
        next_fifo_level = fifo_byte_level;
        if (fifo_push && !fifo_pop && fifo_byte_level != `AHTS_FIFO_FULL) begin
            next_fifo_level = fifo_byte_level + 6'h01;
        end else if (fifo_pop && !fifo_push && fifo_byte_level != 6'h00) begin
            next_fifo_level = fifo_byte_level - 6'h01;
        end
        if (fifo_reset_bit) begin
            next_fifo_level = `AHTS_FIFO_RESET;
        end
    end

    // fifo occupancy counter
    always_ff @(posedge clk) begin
        if (reset) begin
            fifo_byte_level <= 6'h00;
        end else begin
            fifo_byte_level <= next_fifo_level;
        end
    end

    // dma command flag, updated on every valid command
    always_ff @(posedge clk) begin
        if (reset) begin
            dma_command_seen <= 1'b0;
        end else if (new_command) begin
            dma_command_seen <= command_is_dma;
        end
    end

    // ninth sector count bit, set wins over clear
    always_ff @(posedge clk) begin
        if (reset) begin
            sector_count_ninth_bit <= 1'b0;
        end else if (sector_count_load && sector_count_load_value == 8'h00) begin
            sector_count_ninth_bit <= 1'b1;
        end else if (sector_count_decrement || ninth_clear_ok) begin
            sector_count_ninth_bit <= 1'b0;
        end
    end

    // count zero flag, the one-to-zero step wins over a load
    always_ff @(posedge clk) begin
        if (reset) begin
            sector_count_zero <= 1'b0;
        end else if (sector_count_decrement && taskfile_sector_count == 8'h01) begin
            sector_count_zero <= 1'b1;
        end else if (sector_count_load) begin
            sector_count_zero <= 1'b0;
        end
    end

    // host transfer counter and check phase
    always_ff @(posedge clk) begin
        if (reset) begin
            host_bytes_remaining <= 10'h000;
            host_check_phase <= 1'b0;
        end else if (xfer_start) begin
            host_bytes_remaining <= sector_size;
            host_check_phase <= 1'b0;
        end else if (enter_check) begin
            host_bytes_remaining <= {4'h0, check_size};
            host_check_phase <= 1'b1;
        end else if (host_byte && host_bytes_remaining != 10'h000) begin
            host_bytes_remaining <= host_bytes_remaining - 10'h001;
            if (check_boundary) begin
                host_check_phase <= 1'b0;
            end
        end
    end

    // programmable check size
    always_ff @(posedge clk) begin
        if (reset) begin
            check_size <= 6'h00;
        end else if (wr_check_size) begin
            check_size <= reg_wdata[5:0];
        end
    end

    // buffer side check counter
    always_ff @(posedge clk) begin
        if (reset) begin
            check_progress <= 6'h00;
            buffer_check_phase <= 1'b0;
        end else if (xfer_start) begin
            check_progress <= check_size;
            buffer_check_phase <= 1'b0;
        end else if (buffer_sector_done && long_command && check_size != 6'h00) begin
            check_progress <= 6'h00;
            buffer_check_phase <= 1'b1;
        end else if (buffer_byte && buffer_check_phase) begin
            check_progress <= check_progress + 6'h01;
            if (buffer_check_last) begin
                buffer_check_phase <= 1'b0;
            end
        end
    end

    // done flags; a setting event wins over the clear
    always_ff @(posedge clk) begin
        if (reset) begin
            host_side_done <= 1'b0;
            buffer_side_done <= 1'b0;
            sector_complete_status <= 1'b0;
            host_check_done <= 1'b0;
            buffer_check_done <= 1'b0;
        end else begin
            host_side_done <= data_boundary ||
                (host_side_done && !xfer_start && !new_command);
            buffer_side_done <= buffer_sector_done ||
                (buffer_side_done && !xfer_start && !new_command);
            sector_complete_status <= data_boundary ||
                (sector_complete_status && !xfer_start && !new_command);
            host_check_done <= check_boundary ||
                (host_check_done && !xfer_start && !new_command);
            buffer_check_done <= buffer_check_last ||
                (buffer_check_done && !new_command);
        end
    end

    assign transfer_done_irq_status = sector_complete_status;

    // access mode decode
    ahts_mode_decode u_mode (
        .access_mode_index(card_option.access_mode_index),
        .access_mode(access_mode)
    );

    // read data selection
    always_comb begin
        case (reg_addr)
            `AHTS_OFF_START_MATCH: next_rdata = {1'b0, dma_command_seen, head_at_limit,
                sector_at_limit, 1'b0, start_drivehead_match, start_cylinder_match,
                start_sector_match};
            `AHTS_OFF_TASK_MIRROR: next_rdata = {host_data_request_mirror, host_busy_mirror,
                host_timer_zero, 1'b0, sector_count_ninth_bit, sector_count_zero,
                block_counter_zero, request_gen_enable_view};
            `AHTS_OFF_FIFO_LEVEL: next_rdata = {2'b00, fifo_byte_level};
            `AHTS_OFF_XFER_LOW: next_rdata = host_bytes_remaining[7:0];
            `AHTS_OFF_XFER_HIGH: next_rdata = {host_check_phase, host_side_done,
                buffer_side_done, host_check_done, buffer_check_done, sector_complete_status,
                host_bytes_remaining[9:8]};
            `AHTS_OFF_CHECK_SIZE: next_rdata = {2'b00, check_size};
            `AHTS_OFF_CHECK_PROG: next_rdata = {any_check_phase, 1'b0, check_progress};
            `AHTS_OFF_CARD_OPTION: next_rdata = {card_option.card_soft_reset,
                card_option.level_irq_select, 1'b0, card_option.option_spare_bit,
                card_option.access_mode_index};
            default: next_rdata = 8'h00;
        endcase
    end

    // read data register, valid the cycle after the strobe
    always_ff @(posedge clk) begin
        if (reset) begin
            reg_rdata <= `AHTS_RESET_BYTE;
        end else begin
            reg_rdata <= reg_read ? next_rdata : 8'h00;
        end
    end

    // checks
    fifo_bound_a: assert property (@(posedge clk) disable iff (reset)
        fifo_byte_level <= `AHTS_FIFO_FULL) else $error("fifo level over full");
    fifo_reset_a: assert property (@(posedge clk) disable iff (reset)
        fifo_reset_bit |=> fifo_byte_level == 6'h00) else $error("fifo not reset");
    dma_flag_a: assert property (@(posedge clk) disable iff (reset)
        new_command |=> dma_command_seen == $past(command_is_dma)) else $error("dma flag");
    ninth_set_a: assert property (@(posedge clk) disable iff (reset)
        sector_count_load && sector_count_load_value == 8'h00 |=> sector_count_ninth_bit)
        else $error("ninth bit not set");
    ninth_guard_a: assert property (@(posedge clk) disable iff (reset)
        sector_count_ninth_bit && wr_mirror && !host_busy_mirror && !sector_count_decrement
        |=> sector_count_ninth_bit) else $error("ninth cleared while idle");
    count_zero_a: assert property (@(posedge clk) disable iff (reset)
        sector_count_load && !sector_count_decrement |=> !sector_count_zero)
        else $error("count zero kept");
    count_set_a: assert property (@(posedge clk) disable iff (reset)
        sector_count_decrement && taskfile_sector_count == 8'h01 |=> sector_count_zero)
        else $error("count zero missed");
    ninth_clear_a: assert property (@(posedge clk) disable iff (reset)
        ninth_clear_ok && !sector_count_load |=> !sector_count_ninth_bit)
        else $error("ninth bit not cleared");
    ninth_decr_a: assert property (@(posedge clk) disable iff (reset)
        sector_count_decrement && !sector_count_load |=> !sector_count_ninth_bit)
        else $error("ninth kept on decrement");
    host_done_a: assert property (@(posedge clk) disable iff (reset)
        data_boundary |=> host_side_done && sector_complete_status)
        else $error("host done missed");
    buffer_done_a: assert property (@(posedge clk) disable iff (reset)
        buffer_sector_done |=> buffer_side_done)
        else $error("buffer done missed");
    start_clear_a: assert property (@(posedge clk) disable iff (reset)
        xfer_start && !data_boundary && !buffer_sector_done |=> !host_side_done &&
        !buffer_side_done) else $error("done kept at start");
    buffer_check_a: assert property (@(posedge clk) disable iff (reset)
        buffer_check_last |=> buffer_check_done && !buffer_check_phase)
        else $error("buffer check done missed");
    progress_load_a: assert property (@(posedge clk) disable iff (reset)
        xfer_start |=> check_progress == $past(check_size) && !any_check_phase)
        else $error("progress not loaded");
    xfer_load_a: assert property (@(posedge clk) disable iff (reset)
        xfer_start |=> host_bytes_remaining == $past(sector_size) && !host_check_phase)
        else $error("counter not loaded");
    check_enter_a: assert property (@(posedge clk) disable iff (reset)
        enter_check && !xfer_start |=> host_check_phase && host_side_done)
        else $error("check phase missed");
    done_clear_a: assert property (@(posedge clk) disable iff (reset)
        new_command && !data_boundary |=> !host_side_done && !sector_complete_status)
        else $error("done not cleared");
    check_done_a: assert property (@(posedge clk) disable iff (reset)
        check_boundary |=> host_check_done) else $error("check done missed");
    read_data_a: assert property (@(posedge clk) disable iff (reset)
        reg_read && reg_addr == `AHTS_OFF_CHECK_SIZE |=> reg_rdata == {2'b00, $past(check_size)})
        else $error("size readback");
    cover_check_c: cover property (@(posedge clk) disable iff (reset) enter_check);
    cover_done_c: cover property (@(posedge clk) disable iff (reset) buffer_check_last);
    cover_full_c: cover property (@(posedge clk) disable iff (reset)
        fifo_byte_level == `AHTS_FIFO_FULL);
    cover_ninth_c: cover property (@(posedge clk) disable iff (reset) ninth_clear_ok);
    cover_mode_c: cover property (@(posedge clk) disable iff (reset)
        access_mode == ahts_pkg::AHTS_MODE_SECONDARY_FLOPPY);
endmodule

/* verif/ahts_host_model.sv */
// host-side partner: task file, status, option image and command strobes
`timescale 1ns/100ps
module ahts_host_model (
    // clock
    input wire logic clk,
    // task file and option images
    output ahts_pkg::ahts_addr_s taskfile_regs,
    output logic [7:0] taskfile_status,
    output logic [7:0] taskfile_sector_count,
    output ahts_pkg::ahts_option_s card_option,
    // command strobe and levels
    output logic command_load,
    output logic command_is_dma,
    output logic command_for_this_drive,
    output logic long_command,
    // sector count strobes
    output logic sector_count_load,
    output logic [7:0] sector_count_load_value,
    output logic sector_count_decrement
);
    // quiet host at time zero
    initial begin
        {taskfile_regs, taskfile_status, taskfile_sector_count, card_option} = '0;
        {command_load, command_is_dma, command_for_this_drive, long_command} = '0;
        {sector_count_load, sector_count_load_value, sector_count_decrement} = '0;
    end
    // host rewrites task file, status and option image, one edge to settle
    task automatic set_file(input ahts_pkg::ahts_addr_s t, input logic [7:0] st,
        input ahts_pkg::ahts_option_s o);
        @(posedge clk);
        taskfile_regs <= t;
        taskfile_status <= st;
        card_option <= o;
        @(posedge clk);
    endtask
    // one command write, levels stay until the next command
    task automatic issue(input logic dma, input logic mine, input logic lng);
        @(posedge clk);
        command_load <= 1'b1;
        command_is_dma <= dma;
        command_for_this_drive <= mine;
        long_command <= lng;
        @(posedge clk);
        command_load <= 1'b0;
    endtask
    // count load; the value lines go stale once the strobe drops
    task automatic load_count(input logic [7:0] v);
        @(posedge clk);
        sector_count_load <= 1'b1;
        sector_count_load_value <= v;
        @(posedge clk);
        sector_count_load <= 1'b0;
        sector_count_load_value <= ~v;
        taskfile_sector_count <= v;
    endtask
    // decrement; count register shows the old value while sampled
    task automatic dec_count();
        @(posedge clk);
        sector_count_decrement <= 1'b1;
        @(posedge clk);
        sector_count_decrement <= 1'b0;
        taskfile_sector_count <= taskfile_sector_count - 8'h01;
    endtask
endmodule

/* verif/ahts_status_bank_tb.sv */
// self-checking bench for the host transfer status bank
`timescale 1ns/100ps
module ahts_status_bank_tb;
    logic clk, reset, reg_write, reg_read, lba_command_active, command_load, command_is_dma;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, sector_limit_drive0, sector_limit_drive1;
    logic [7:0] taskfile_status, taskfile_sector_count, sector_count_load_value;
    logic [7:0] host_timer_value, block_counter_value;
    logic [3:0] head_limit_field;
    logic [9:0] sector_size;
    logic command_for_this_drive, long_command, sector_count_load, sector_count_decrement;
    logic request_gen_enable_view, fifo_reset_bit, fifo_push, fifo_pop, xfer_start;
    logic host_byte, buffer_byte, buffer_sector_done, transfer_done_irq_status, exp_dma;
    ahts_pkg::ahts_addr_s start_regs, taskfile_regs;
    ahts_pkg::ahts_option_s card_option;
    ahts_pkg::ahts_mode_e access_mode;
    int err_count = 0;
    int checks_done = 0;
    logic [31:0] seed = 32'hfd65fa9d;

    ahts_status_bank ahts_status_bank_i (.clk, .reset, .reg_addr, .reg_wdata, .reg_write,
        .reg_read, .reg_rdata, .start_regs, .taskfile_regs, .head_limit_field,
        .sector_limit_drive0, .sector_limit_drive1, .taskfile_status, .lba_command_active,
        .command_load, .command_is_dma, .command_for_this_drive, .long_command,
        .host_timer_value, .block_counter_value, .sector_count_load, .sector_count_load_value,
        .sector_count_decrement, .taskfile_sector_count, .request_gen_enable_view,
        .fifo_reset_bit, .fifo_push, .fifo_pop, .xfer_start, .sector_size, .host_byte,
        .buffer_byte, .buffer_sector_done, .card_option, .transfer_done_irq_status,
        .access_mode);
    ahts_host_model ahts_host_model_i (.clk, .taskfile_regs, .taskfile_status,
        .taskfile_sector_count, .card_option, .command_load, .command_is_dma,
        .command_for_this_drive, .long_command, .sector_count_load, .sector_count_load_value,
        .sector_count_decrement);

    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // linear feedback shift register source
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04c11db7 : 32'h0);
        return seed;
    endfunction
    // expected start-compare byte
    function automatic logic [7:0] exp_cd();
        logic [7:0] lim;
        lim = taskfile_regs.drive_head[4] ? sector_limit_drive1 : sector_limit_drive0;
        return {1'b0, exp_dma, start_regs.drive_head[3:0] == head_limit_field,
            start_regs.sector_number == lim, 1'b0,
            start_regs.drive_head == taskfile_regs.drive_head,
            {start_regs.cylinder_low, start_regs.cylinder_high}
                == {taskfile_regs.cylinder_low, taskfile_regs.cylinder_high},
            start_regs.sector_number == taskfile_regs.sector_number};
    endfunction
    // expected mirror byte, count bits left out
    function automatic logic [7:0] exp_ce();
        return {taskfile_status[3], taskfile_status[7], host_timer_value == 8'h00, 3'b000,
            block_counter_value == 8'h00, request_gen_enable_view};
    endfunction
    task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask
    // read, data looked at in the one cycle it stands
    task automatic rdchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 check($sformatf("reg %h", a), {2'b00, reg_rdata & m}, {2'b00, e & m});
    endtask
    // n back-to-back strobes: 0 push 1 pop 2 host 3 buffer 4 start 5 buffer sector
    task automatic pulse(input int k, input int n);
        repeat (n) begin
            @(posedge clk);
            {buffer_sector_done, xfer_start, buffer_byte, host_byte, fifo_pop, fifo_push}
                <= 6'(1 << k);
        end
        @(posedge clk);
        {buffer_sector_done, xfer_start, buffer_byte, host_byte, fifo_pop, fifo_push} <= '0;
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // hang guard
    initial begin
        #200000;
        err_count++;
        complete_run();
    end
    // main sequence
    initial begin
        int sz, ec;
        logic [31:0] r;
        logic [3:0] dm, mn;
        ahts_pkg::ahts_addr_s s, t;
        ahts_pkg::ahts_option_s o;
        {reg_write, reg_read, reg_addr, reg_wdata, lba_command_active, fifo_reset_bit} = '0;
        {fifo_push, fifo_pop, xfer_start, host_byte, buffer_byte, buffer_sector_done} = '0;
        {start_regs, head_limit_field, sector_limit_drive0, sector_limit_drive1} = '0;
        {host_timer_value, block_counter_value, request_gen_enable_view, sector_size} = '0;
        {exp_dma, dm, mn, o} = {1'b0, 4'b1011, 4'b1101, 7'h00};
        reset = 1'b1;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        rdchk(8'hcf, 8'hff, 8'h00);
        rdchk(8'hd1, 8'hff, 8'h00);
        // random compares, mirrors and zero detects
        for (int i = 0; i < 32; i++) begin
            s = rnd();
            t = rnd();
            r = rnd();
            if (i[0]) t.sector_number = s.sector_number;
            if (i[1]) t.cylinder_low = s.cylinder_low;
            if (i[2]) t.cylinder_high = s.cylinder_high;
            if (i[3]) t.drive_head = s.drive_head;
            @(posedge clk);
            start_regs <= s;
            head_limit_field <= i[2] ? s.drive_head[3:0] : r[3:0];
            sector_limit_drive0 <= i[3] ? s.sector_number : r[11:4];
            sector_limit_drive1 <= i[4] ? s.sector_number : r[19:12];
            host_timer_value <= i[1] ? 8'h00 : r[27:20];
            block_counter_value <= i[2] ? 8'h00 : r[31:24];
            request_gen_enable_view <= r[5];
            ahts_host_model_i.set_file(t, r[12:5], o);
            rdchk(8'hcd, 8'hff, exp_cd());
            rdchk(8'hce, 8'he3, exp_ce());
        end
        wr(8'hcd, 8'hff);
        rdchk(8'hcd, 8'hff, exp_cd());
        rdchk(8'h55, 8'hff, 8'h00);
        // dma flag follows only commands for this drive
        for (int k = 0; k < 4; k++) begin
            ahts_host_model_i.issue(dm[k], mn[k], 1'b0);
            if (mn[k]) exp_dma = dm[k];
            rdchk(8'hcd, 8'h40, {1'b0, exp_dma, 6'h00});
        end
        // ninth count bit and count-zero flag
        ahts_host_model_i.set_file(t, 8'h00, o);
        ahts_host_model_i.load_count(8'h00);
        rdchk(8'hce, 8'h0c, 8'h08);
        wr(8'hce, 8'h00);
        rdchk(8'hce, 8'h0c, 8'h08);
        ahts_host_model_i.set_file(t, 8'h80, o);
        wr(8'hce, 8'h00);
        rdchk(8'hce, 8'h0c, 8'h00);
        ahts_host_model_i.load_count(8'h00);
        ahts_host_model_i.dec_count();
        rdchk(8'hce, 8'h0c, 8'h00);
        ahts_host_model_i.load_count(8'h01);
        ahts_host_model_i.dec_count();
        rdchk(8'hce, 8'h0c, 8'h04);
        ahts_host_model_i.load_count(8'h05);
        rdchk(8'hce, 8'h0c, 8'h00);
        // fifo fill past full, drain, forced clear
        pulse(0, 40);
        rdchk(8'hcf, 8'hff, 8'h20);
        pulse(1, 5);
        rdchk(8'hcf, 8'hff, 8'h1b);
        @(posedge clk);
        fifo_reset_bit <= 1'b1;
        rdchk(8'hcf, 8'hff, 8'h00);
        @(posedge clk);
        fifo_reset_bit <= 1'b0;
        pulse(0, 3);
        rdchk(8'hcf, 8'hff, 8'h03);
        // every access-mode index with random option bits
        for (int k = 0; k < 16; k++) begin
            r = rnd();
            o = {r[2:0], k[3:0]};
            ahts_host_model_i.set_file(t, 8'h80, o);
            rdchk(8'he0, 8'hdf, {o[6:5], 1'b0, o[4:0]});
            check("mode", {6'h00, access_mode}, k < 6 ? 10'(k) : 10'h006);
        end
        // long-command sectors at both size limits and a random one
        for (int q = 0; q < 3; q++) begin
            r = rnd();
            sz = q == 0 ? 1 : q == 1 ? 1023 : 4 + int'(r[5:0]);
            ec = q == 0 ? 1 : q == 1 ? 63 : 1 + int'(r[8:6]);
            @(posedge clk);
            sector_size <= 10'(sz);
            wr(8'hd2, {2'b11, 6'(ec)});
            rdchk(8'hd2, 8'h3f, 8'(ec));
            ahts_host_model_i.issue(1'b0, 1'b1, 1'b1);
            pulse(4, 1);
            rdchk(8'hd0, 8'hff, 8'(sz));
            rdchk(8'hd1, 8'hff, 8'(sz >> 8));
            rdchk(8'hd3, 8'hbf, 8'(ec));
            pulse(2, sz - 1);
            rdchk(8'hd0, 8'hff, 8'h01);
            pulse(2, 1);
            rdchk(8'hd1, 8'hff, 8'hc4);
            rdchk(8'hd0, 8'hff, 8'(ec));
            check("irq", {9'h000, transfer_done_irq_status}, 10'h001);
            pulse(2, ec);
            rdchk(8'hd1, 8'hff, 8'h54);
            pulse(5, 1);
            rdchk(8'hd1, 8'hff, 8'h74);
            rdchk(8'hd3, 8'hbf, 8'h80);
            pulse(3, ec);
            rdchk(8'hd1, 8'hff, 8'h7c);
            rdchk(8'hd3, 8'hbf, 8'(ec));
            pulse(4, 1);
            rdchk(8'hd1, 8'hff, 8'h08 | 8'(sz >> 8));
            check("irq", {9'h000, transfer_done_irq_status}, 10'h000);
            ahts_host_model_i.issue(1'b0, 1'b1, 1'b0);
            rdchk(8'hd1, 8'hfc, 8'h00);
        end
        complete_run();
    end
endmodule
